// ### inc/dvic_regs.svh
`ifndef DVIC_REGS_SVH
`define DVIC_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define DVIC_A_NORM_STAT  32'hffff0000
`define DVIC_A_NORM_RAW   32'hffff0004
`define DVIC_A_NORM_EN    32'hffff0008
`define DVIC_A_NORM_CLR   32'hffff000c
`define DVIC_A_SWI        32'hffff0010
`define DVIC_A_BASE       32'hffff0014
`define DVIC_A_VEC        32'hffff001c
`define DVIC_A_PRIO_A     32'hffff0020
`define DVIC_A_PRIO_B     32'hffff0024
`define DVIC_A_PRIO_C     32'hffff0028
`define DVIC_A_NEST       32'hffff0030
`define DVIC_A_FAST_STAT  32'hffff0100
`define DVIC_A_FAST_RAW   32'hffff0104
`define DVIC_A_FAST_EN    32'hffff0108
`define DVIC_A_FAST_CLR   32'hffff010c

// ----------------------------------------------------------------
// reset values, writable masks and field positions
// ----------------------------------------------------------------
`define DVIC_RST_WORD     32'h00000000
`define DVIC_PRIO_A_MASK  32'h77777770
`define DVIC_PRIO_B_MASK  32'h77777777
`define DVIC_PRIO_C_MASK  32'h00007777
`define DVIC_NEST_MASK    32'h00000003
`define DVIC_SWI_NORM_BIT 1
`define DVIC_SWI_FAST_BIT 2
`define DVIC_SWI_SRC_BIT  1
`define DVIC_CHAIN_BIT    0
`define DVIC_NEST_NORM    0
`define DVIC_NEST_FAST    1
`define DVIC_VEC_IDX_LSB  2
`define DVIC_VEC_BASE_LSB 7
`define DVIC_NUM_SRC      20

`endif

// ### inc/dvic_pkg.sv
package dvic_pkg;
    typedef logic [31:0] dvic_word_t;
    typedef logic [15:0] dvic_base_t;
    typedef logic [2:0]  dvic_prio_t;
    typedef logic [4:0]  dvic_idx_t;
    // decoded register selection
    typedef enum logic [3:0] {
        DVIC_R_NONE, DVIC_R_NSTAT, DVIC_R_NRAW, DVIC_R_NEN, DVIC_R_NCLR,
        DVIC_R_SWI, DVIC_R_BASE, DVIC_R_VEC, DVIC_R_PA, DVIC_R_PB,
        DVIC_R_PC, DVIC_R_NEST, DVIC_R_FSTAT, DVIC_R_FRAW, DVIC_R_FEN,
        DVIC_R_FCLR
    } dvic_sel_t;
endpackage

// ### inc/dvic_mask_if.sv
`timescale 1ns/1ps
// enable-mask update strobes and the two masks they steer
interface dvic_mask_if;
    logic               set_norm;
    logic               clr_norm;
    logic               set_fast;
    logic               clr_fast;
    dvic_pkg::dvic_word_t wdata;
    dvic_pkg::dvic_word_t norm_en;
    dvic_pkg::dvic_word_t fast_en;
    modport ctrl (output set_norm, output clr_norm, output set_fast,
                  output clr_fast, output wdata,
                  input norm_en, input fast_en);
    modport mask (input set_norm, input clr_norm, input set_fast,
                  input clr_fast, input wdata,
                  output norm_en, output fast_en);
endinterface

// ### core/dvic_mask.sv
`timescale 1ns/1ps
`include "dvic_regs.svh"

// ----------------------------------------------------------------
// set-only / clear-only enable masks for both levels
// ----------------------------------------------------------------
module dvic_mask (
    // clock and reset
    input wire logic  core_clk,
    input wire logic  resetn,
    // strobes and masks
    dvic_mask_if.mask mif
);
    dvic_pkg::dvic_word_t norm_en_q;
    dvic_pkg::dvic_word_t fast_en_q;

    // normal mask: ones set, clear port and fast set remove bits
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            norm_en_q <= `DVIC_RST_WORD;
        end else if (mif.set_norm) begin
            norm_en_q <= norm_en_q | mif.wdata;
        end else if (mif.clr_norm) begin
            norm_en_q <= norm_en_q & ~mif.wdata;
        end else if (mif.set_fast) begin
            norm_en_q <= norm_en_q & ~mif.wdata;
        end
    end

    // fast mask: mirror image, so a source never sits in both
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fast_en_q <= `DVIC_RST_WORD;
        end else if (mif.set_fast) begin
            fast_en_q <= fast_en_q | mif.wdata;
        end else if (mif.clr_fast) begin
            fast_en_q <= fast_en_q & ~mif.wdata;
        end else if (mif.set_norm) begin
            fast_en_q <= fast_en_q & ~mif.wdata;
        end
    end

    assign mif.norm_en = norm_en_q;
    assign mif.fast_en = fast_en_q;
endmodule // dvic_mask

// ### core/dvic_prio.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// priority arbiter: lowest level wins, ties go to the lower index
// ----------------------------------------------------------------
module dvic_prio #(
    parameter int NUM_SRC = 20
) (
    // pending requests and their levels
    input wire logic [NUM_SRC-1:0]   req,
    input wire logic [3*NUM_SRC-1:0] prio_flat,
    // winner
    output logic [4:0]               win_idx,
    output logic                     win_vld
);
    logic [3:0] best;

    // linear scan; 20 sources fit one 5 ns cycle comfortably
    always_comb begin
        best    = 4'h8;
        win_idx = 5'h00;
        win_vld = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && ({1'b0, prio_flat[3*i +: 3]} < best)) begin
                best    = {1'b0, prio_flat[3*i +: 3]};
                win_idx = 5'(i);
                win_vld = 1'b1;
            end
        end
    end
endmodule // dvic_prio

// ### core/dvic_top.sv
// Functional notes
// - normal set port only enables sources
// - normal clear port clears written ones
// - normal status is raw AND enable
// - normal exception is OR of status
// - fast status is raw AND enable
// - fast bits 31:1 OR drive exception, bit0
// - fast set clears same normal enable
// - normal set clears same fast enable
// - fast set port only enables sources
// - fast clear port clears written ones
// - fast raw follows peripheral request, read-only
// - normal raw follows peripheral request, read-only
// - soft interrupts bypass masks, hit raw+status
// - soft bit 2 drives fast bit 1
// - soft bit 1 drives normal bit 1
// - nest bit 0 gates the normal vector index, bit 1 gates nothing
// - eight levels for normal sources, fast above normal
// - each source has 3-bit priority
// - level 0 highest, level 7 lowest
// - base holds 16 bits, upper zero
`timescale 1ns/1ps
`include "dvic_regs.svh"

module dvic_top #(
    parameter int NUM_SRC = `DVIC_NUM_SRC
) (
    // clock and reset
    input wire logic         core_clk,
    input wire logic         resetn,
    // register port
    input wire logic [31:0]  reg_addr,
    input wire logic [31:0]  reg_wdata,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    output logic [31:0]      reg_rdata,
    // peripheral request lines
    input wire logic [31:0]  norm_src_in,
    input wire logic [31:0]  fast_src_in,
    // core exception inputs
    output logic             norm_exc,
    output logic             fast_exc
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    // shared by the write and read paths; unaligned or
    // unlisted addresses fall to none
    function automatic dvic_pkg::dvic_sel_t decode(
        input logic [31:0] a
    );
        dvic_pkg::dvic_sel_t s;
        s = dvic_pkg::DVIC_R_NONE;
        case (a)
            `DVIC_A_NORM_STAT: s = dvic_pkg::DVIC_R_NSTAT;
            `DVIC_A_NORM_RAW:  s = dvic_pkg::DVIC_R_NRAW;
            `DVIC_A_NORM_EN:   s = dvic_pkg::DVIC_R_NEN;
            `DVIC_A_NORM_CLR:  s = dvic_pkg::DVIC_R_NCLR;
            `DVIC_A_SWI:       s = dvic_pkg::DVIC_R_SWI;
            `DVIC_A_BASE:      s = dvic_pkg::DVIC_R_BASE;
            `DVIC_A_VEC:       s = dvic_pkg::DVIC_R_VEC;
            `DVIC_A_PRIO_A:    s = dvic_pkg::DVIC_R_PA;
            `DVIC_A_PRIO_B:    s = dvic_pkg::DVIC_R_PB;
            `DVIC_A_PRIO_C:    s = dvic_pkg::DVIC_R_PC;
            `DVIC_A_NEST:      s = dvic_pkg::DVIC_R_NEST;
            `DVIC_A_FAST_STAT: s = dvic_pkg::DVIC_R_FSTAT;
            `DVIC_A_FAST_RAW:  s = dvic_pkg::DVIC_R_FRAW;
            `DVIC_A_FAST_EN:   s = dvic_pkg::DVIC_R_FEN;
            `DVIC_A_FAST_CLR:  s = dvic_pkg::DVIC_R_FCLR;
            default:           s = dvic_pkg::DVIC_R_NONE;
        endcase
        return s;
    endfunction

    dvic_pkg::dvic_sel_t wsel;
    dvic_pkg::dvic_sel_t rsel;

    // a write to an unmapped address is dropped silently
    assign wsel = reg_wr ? decode(reg_addr) : dvic_pkg::DVIC_R_NONE;
    assign rsel = decode(reg_addr);

    // ----------------------------------------------------------------
    // software-owned registers
    // ----------------------------------------------------------------

    logic                 swi_norm_q;
    logic                 swi_fast_q;
    dvic_pkg::dvic_base_t base_q;
    dvic_pkg::dvic_word_t prio_a_q;
    dvic_pkg::dvic_word_t prio_b_q;
    dvic_pkg::dvic_word_t prio_c_q;
    logic [1:0]           nest_q;

    // programmed interrupt bits; a write both sets and clears
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            swi_norm_q <= 1'b0;
            swi_fast_q <= 1'b0;
        end else if (wsel == dvic_pkg::DVIC_R_SWI) begin
            swi_norm_q <= reg_wdata[`DVIC_SWI_NORM_BIT];
            swi_fast_q <= reg_wdata[`DVIC_SWI_FAST_BIT];
        end
    end

    // vector base, only the low half is storage
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            base_q <= 16'h0000;
        end else if (wsel == dvic_pkg::DVIC_R_BASE) begin
            base_q <= reg_wdata[15:0];
        end
    end

    // priority levels, three bits per nibble, reserved bits held at zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prio_a_q <= `DVIC_RST_WORD;
            prio_b_q <= `DVIC_RST_WORD;
            prio_c_q <= `DVIC_RST_WORD;
        end else begin
            if (wsel == dvic_pkg::DVIC_R_PA) begin
                prio_a_q <= reg_wdata & `DVIC_PRIO_A_MASK;
            end
            if (wsel == dvic_pkg::DVIC_R_PB) begin
                prio_b_q <= reg_wdata & `DVIC_PRIO_B_MASK;
            end
            if (wsel == dvic_pkg::DVIC_R_PC) begin
                prio_c_q <= reg_wdata & `DVIC_PRIO_C_MASK;
            end
        end
    end

    // nesting control: bit 0 normal, bit 1 fast
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nest_q <= 2'b00;
        end else if (wsel == dvic_pkg::DVIC_R_NEST) begin
            nest_q <= reg_wdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // enable masks
    // ----------------------------------------------------------------

    dvic_mask_if mif ();

    // strobes are exclusive, so at most one mask update per cycle
    assign mif.set_norm = (wsel == dvic_pkg::DVIC_R_NEN);
    assign mif.clr_norm = (wsel == dvic_pkg::DVIC_R_NCLR);
    assign mif.set_fast = (wsel == dvic_pkg::DVIC_R_FEN);
    assign mif.clr_fast = (wsel == dvic_pkg::DVIC_R_FCLR);
    assign mif.wdata    = reg_wdata;

    dvic_mask u_mask (
        .core_clk (core_clk),
        .resetn   (resetn),
        .mif      (mif.mask)
    );

    // ----------------------------------------------------------------
    // raw sources and masked status
    // ----------------------------------------------------------------

    dvic_pkg::dvic_word_t fast_raw;
    dvic_pkg::dvic_word_t fast_stat;
    dvic_pkg::dvic_word_t norm_raw;
    dvic_pkg::dvic_word_t norm_stat;
    logic [31:1]          fast_hi_raw;
    logic [31:1]          fast_hi_stat;
    logic                 fast_chain;

    // upper fast bits: peripheral lines plus the programmed source,
    // which skips the mask entirely
    always_comb begin
        fast_hi_raw  = fast_src_in[31:1];
        fast_hi_raw[`DVIC_SWI_SRC_BIT] = fast_src_in[`DVIC_SWI_SRC_BIT]
                                         | swi_fast_q;
        fast_hi_stat = fast_hi_raw & mif.fast_en[31:1];
        fast_hi_stat[`DVIC_SWI_SRC_BIT] = (fast_src_in[`DVIC_SWI_SRC_BIT]
                                           & mif.fast_en[`DVIC_SWI_SRC_BIT])
                                          | swi_fast_q;
    end

    // bit 0 of both maps carries the fast summary, taken from bits
    // 31:1 only so the fast path has no combinational loop
    assign fast_chain = |fast_hi_stat;

    assign fast_raw  = {fast_hi_raw, fast_chain};
    assign fast_stat = {fast_hi_stat,
                        fast_chain & mif.fast_en[`DVIC_CHAIN_BIT]};

    // normal map: same build, programmed bit from the normal soft bit
    always_comb begin
        norm_raw = {norm_src_in[31:1], fast_chain};
        norm_raw[`DVIC_SWI_SRC_BIT] = norm_src_in[`DVIC_SWI_SRC_BIT]
                                      | swi_norm_q;
        norm_stat = norm_raw & mif.norm_en;
        norm_stat[`DVIC_SWI_SRC_BIT] = (norm_src_in[`DVIC_SWI_SRC_BIT]
                                        & mif.norm_en[`DVIC_SWI_SRC_BIT])
                                       | swi_norm_q;
    end

    // ----------------------------------------------------------------
    // exception outputs
    // ----------------------------------------------------------------

    // registered so the core sees glitch-free levels; costs one cycle
    // of latency, which is why requests must be held
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            norm_exc <= 1'b0;
            fast_exc <= 1'b0;
        end else begin
            norm_exc <= |norm_stat;
            fast_exc <= fast_chain;
        end
    end

    // ----------------------------------------------------------------
    // priority arbitration and vector
    // ----------------------------------------------------------------

    logic [95:0]            prio_all;
    logic [3*NUM_SRC-1:0]   prio_flat;
    logic [4:0]             win_idx;
    logic                   win_vld;
    dvic_pkg::dvic_word_t   vec_word;

    assign prio_all = {prio_c_q, prio_b_q, prio_a_q};

    // source i takes the low three bits of nibble i
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_prio
        assign prio_flat[3*g +: 3] = prio_all[4*g +: 3];
    end

    // only normal sources are arbitrated; a pending fast request
    // already preempts through its own exception line
    dvic_prio #(
        .NUM_SRC (NUM_SRC)
    ) u_prio (
        .req       (norm_stat[NUM_SRC-1:0]),
        .prio_flat (prio_flat),
        .win_idx   (win_idx),
        .win_vld   (win_vld)
    );

    // with normal nesting off no index is generated
    always_comb begin
        vec_word = `DVIC_RST_WORD;
        vec_word[`DVIC_VEC_BASE_LSB +: 16] = base_q;
        if (nest_q[`DVIC_NEST_NORM] && win_vld) begin
            vec_word[`DVIC_VEC_IDX_LSB +: 5] = win_idx;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------

    dvic_pkg::dvic_word_t rdata_q;

    // data stand only in the cycle after the read strobe; write-only
    // and unmapped locations answer zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= `DVIC_RST_WORD;
        end else if (!reg_rd) begin
            rdata_q <= `DVIC_RST_WORD;
        end else begin
            case (rsel)
                dvic_pkg::DVIC_R_NSTAT: rdata_q <= norm_stat;
                dvic_pkg::DVIC_R_NRAW:  rdata_q <= norm_raw;
                dvic_pkg::DVIC_R_NEN:   rdata_q <= mif.norm_en;
                dvic_pkg::DVIC_R_BASE:  rdata_q <= {16'h0000, base_q};
                dvic_pkg::DVIC_R_VEC:   rdata_q <= vec_word;
                dvic_pkg::DVIC_R_PA:    rdata_q <= prio_a_q;
                dvic_pkg::DVIC_R_PB:    rdata_q <= prio_b_q;
                dvic_pkg::DVIC_R_PC:    rdata_q <= prio_c_q;
                dvic_pkg::DVIC_R_NEST:  rdata_q <= {30'h0, nest_q};
                dvic_pkg::DVIC_R_FSTAT: rdata_q <= fast_stat;
                dvic_pkg::DVIC_R_FRAW:  rdata_q <= fast_raw;
                dvic_pkg::DVIC_R_FEN:   rdata_q <= mif.fast_en;
                default:                rdata_q <= `DVIC_RST_WORD;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

endmodule // dvic_top

// ### dv/dvic_props.sv
`timescale 1ns/1ps
`include "dvic_regs.svh"

// ----------------------------------------------------------------
// port-level checker with mask and soft-bit shadows
// ----------------------------------------------------------------
module dvic_props #(
    parameter int NUM_SRC = 20
) (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // request lines and exceptions
    input wire logic [31:0] norm_src_in,
    input wire logic [31:0] fast_src_in,
    input wire logic        norm_exc,
    input wire logic        fast_exc
);
    logic [31:0] nen_q, fen_q, nraw, fraw, nstat, fstat;
    logic [2:1]  swi_q;
    logic        fsum;

    // enable shadows: own set ORs in, cross set or clear knocks out
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nen_q <= '0;
        end else if (reg_wr && reg_addr == `DVIC_A_NORM_EN) begin
            nen_q <= nen_q | reg_wdata;
        end else if (reg_wr && (reg_addr == `DVIC_A_FAST_EN || reg_addr == `DVIC_A_NORM_CLR)) begin
            nen_q <= nen_q & ~reg_wdata;
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fen_q <= '0;
        end else if (reg_wr && reg_addr == `DVIC_A_FAST_EN) begin
            fen_q <= fen_q | reg_wdata;
        end else if (reg_wr && (reg_addr == `DVIC_A_NORM_EN || reg_addr == `DVIC_A_FAST_CLR)) begin
            fen_q <= fen_q & ~reg_wdata;
        end
    end
    // soft bits held until rewritten
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            swi_q <= '0;
        end else if (reg_wr && reg_addr == `DVIC_A_SWI) begin
            swi_q <= reg_wdata[2:1];
        end
    end
    // predicted maps; summary from bits 31:1 only, no loop
    assign fsum  = |({fast_src_in[31:2], fast_src_in[1] | swi_q[2]} & fen_q[31:1]) | swi_q[2];
    assign fraw  = {fast_src_in[31:2], fast_src_in[1] | swi_q[2], fsum};
    assign fstat = (fraw & fen_q) | {30'h0, swi_q[2], 1'b0};
    assign nraw  = {norm_src_in[31:2], norm_src_in[1] | swi_q[1], fsum};
    assign nstat = (nraw & nen_q) | {30'h0, swi_q[1], 1'b0};

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // read strobe on one address, then its data cycle
    sequence s_read(logic [31:0] a);
        reg_rd && reg_addr == a ##1 1'b1;
    endsequence
    property p_read(logic [31:0] a, logic [31:0] v);
        s_read(a) |-> reg_rdata == v;
    endproperty

    a_norm_exc_or: assert property (norm_exc == $past(nstat != '0))
        else $error("normal exception wrong");
    a_fast_exc_or: assert property (fast_exc == $past(fstat[31:1] != '0))
        else $error("fast exception wrong");
    a_nstat_read: assert property (p_read(`DVIC_A_NORM_STAT, $past(nstat)))
        else $error("normal status read wrong");
    a_fstat_read: assert property (p_read(`DVIC_A_FAST_STAT, $past(fstat)))
        else $error("fast status read wrong");
    a_fraw_read: assert property (p_read(`DVIC_A_FAST_RAW, $past(fraw)))
        else $error("fast raw read wrong");
    a_nraw_read: assert property (p_read(`DVIC_A_NORM_RAW, $past(nraw)))
        else $error("normal raw read wrong");
    a_nen_read: assert property (p_read(`DVIC_A_NORM_EN, $past(nen_q)))
        else $error("normal enable read wrong");
    a_fen_read: assert property (p_read(`DVIC_A_FAST_EN, $past(fen_q)))
        else $error("fast enable read wrong");
    a_base_upper: assert property (s_read(`DVIC_A_BASE) |-> reg_rdata[31:16] == '0)
        else $error("base upper half not zero");
    a_vec_fields: assert property (s_read(`DVIC_A_VEC) |-> reg_rdata[31:23] == '0
        && reg_rdata[1:0] == '0 && reg_rdata[6:2] < NUM_SRC) else $error("vector fields wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("stray read data");
    a_wo_read: assert property (reg_rd && (reg_addr == `DVIC_A_NORM_CLR || reg_addr == `DVIC_A_FAST_CLR
        || reg_addr == `DVIC_A_SWI) |=> reg_rdata == '0) else $error("write-only read nonzero");
endmodule // dvic_props

// ### dv/dvic_periph.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// peripheral side: request lines as held levels
// ----------------------------------------------------------------
module dvic_periph (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // levels commanded by the bench
    input wire logic [31:0] n_lvl,
    input wire logic [31:0] f_lvl,
    // request lines into the controller
    output logic [31:0]     norm_src,
    output logic [31:0]     fast_src
);
    // requests change only after an edge and are held until withdrawn,
    // so none is shorter than the one-cycle sampling window
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            norm_src <= '0;
            fast_src <= '0;
        end else begin
            norm_src <= n_lvl;
            fast_src <= f_lvl;
        end
    end
endmodule // dvic_periph

// ### dv/dvic_tb_top.sv
`timescale 1ns/1ps
`include "dvic_regs.svh"

module dvic_tb_top;
    localparam logic [31:0] NST = `DVIC_A_NORM_STAT;
    localparam logic [31:0] NRW = `DVIC_A_NORM_RAW;
    localparam logic [31:0] NEN = `DVIC_A_NORM_EN;
    localparam logic [31:0] NCL = `DVIC_A_NORM_CLR;
    localparam logic [31:0] SWI = `DVIC_A_SWI;
    localparam logic [31:0] FST = `DVIC_A_FAST_STAT;
    localparam logic [31:0] FRW = `DVIC_A_FAST_RAW;
    localparam logic [31:0] FEN = `DVIC_A_FAST_EN;
    localparam logic [31:0] FCL = `DVIC_A_FAST_CLR;
    // write, address, data, sources, expected read, {norm_exc, fast_exc}
    typedef struct packed {
        logic        wr;
        logic [31:0] addr, data, nsrc, fsrc, exp;
        logic [1:0]  exc;
    } dvic_row_t;

    logic        core_clk, resetn, reg_wr, reg_rd, norm_exc, fast_exc;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, norm_src_in, fast_src_in, n_lvl, f_lvl;
    int          n_errors, tests_run, cyc;
    dvic_row_t   rows [29] = '{
        '{1'b1, NEN, 32'hf0, '0, '0, '0, '0}, '{1'b0, NEN, '0, '0, '0, 32'hf0, '0},
        '{1'b1, NEN, '0, '0, '0, '0, '0}, '{1'b0, NEN, '0, '0, '0, 32'hf0, '0},
        '{1'b1, FEN, 32'h30, '0, '0, '0, '0}, '{1'b0, NEN, '0, '0, '0, 32'hc0, '0},
        '{1'b0, FEN, '0, '0, '0, 32'h30, '0},
        '{1'b1, NCL, 32'h40, '0, '0, '0, '0}, '{1'b0, NEN, '0, '0, '0, 32'h80, '0},
        '{1'b0, NST, '0, 32'hff, 32'hff, 32'h80, 2'b11},
        '{1'b0, FST, '0, 32'hff, 32'hff, 32'h30, 2'b11},
        '{1'b0, FRW, '0, 32'hff, 32'hff, 32'hff, 2'b11},
        '{1'b0, NRW, '0, '0, 32'hff, 32'h1, 2'b01},
        '{1'b1, NEN, 32'h1, '0, 32'hff, '0, '0},
        '{1'b0, NST, '0, '0, 32'hff, 32'h1, 2'b11},
        '{1'b1, FCL, 32'h30, 32'hff, 32'hff, '0, '0},
        '{1'b0, NST, '0, 32'hff, 32'hff, 32'h80, 2'b10},
        '{1'b1, FEN, 32'h100, '0, '0, '0, '0}, '{1'b1, NEN, 32'h100, '0, '0, '0, '0},
        '{1'b0, FEN, '0, '0, '0, '0, '0},
        '{1'b1, SWI, 32'h6, '0, '0, '0, '0}, '{1'b0, NST, '0, '0, '0, 32'h3, 2'b11},
        '{1'b0, FST, '0, '0, '0, 32'h2, 2'b11},
        '{1'b1, SWI, 32'h4, '0, '0, '0, '0}, '{1'b0, NRW, '0, '0, '0, 32'h1, 2'b11},
        '{1'b1, SWI, '0, '0, '0, '0, '0}, '{1'b0, FRW, '0, '0, '0, '0, '0},
        '{1'b1, `DVIC_A_PRIO_C, '1, '0, '0, '0, '0}, '{1'b0, `DVIC_A_PRIO_C, '0, '0, '0, 32'h7777, '0}};
    logic [31:0] rst_addrs [10] = '{NEN, FEN, NST, FST, `DVIC_A_BASE, `DVIC_A_VEC, NCL, SWI, FCL, `DVIC_A_PRIO_C};

    dvic_top dvic_top_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .norm_src_in(norm_src_in),
        .fast_src_in(fast_src_in), .norm_exc(norm_exc), .fast_exc(fast_exc));
    dvic_periph dvic_periph_i (.core_clk(core_clk), .resetn(resetn), .n_lvl(n_lvl), .f_lvl(f_lvl),
        .norm_src(norm_src_in), .fast_src(fast_src_in));

    // ----------------------------------------------------------------
    // report and bus tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_flag(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    // one strobe cycle, back to back allowed
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask
    // drops strobes; last read data settled on return
    task automatic idle();
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
        idle();
    endtask
    task automatic rd_chk(input string n, input logic [31:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        idle();
        chk_word(n, e, reg_rdata);
    endtask

    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, n_lvl, f_lvl} = '0;
        {n_errors, tests_run, cyc} = '0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            n_lvl <= rows[i].nsrc;
            f_lvl <= rows[i].fsrc;
            repeat (3) @(posedge core_clk);
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rd_chk("row read", rows[i].addr, rows[i].exp);
                chk_flag("norm_exc", rows[i].exc[1], norm_exc);
                chk_flag("fast_exc", rows[i].exc[0], fast_exc);
            end
        end
        // vector: source 9 (level 0) beats 5 (level 7), then a tie, then off
        n_lvl <= 32'h220;
        wr(NEN, 32'h220);
        wr(`DVIC_A_BASE, 32'hffffffff);
        rd_chk("base", `DVIC_A_BASE, 32'hffff);
        wr(`DVIC_A_NEST, 32'h1);
        wr(`DVIC_A_PRIO_A, 32'h700000);
        chk_flag("norm_exc", 1'b1, norm_exc);
        rd_chk("vector", `DVIC_A_VEC, 32'h7fffa4);
        wr(`DVIC_A_PRIO_A, '0);
        rd_chk("vector tie", `DVIC_A_VEC, 32'h7fff94);
        wr(`DVIC_A_NEST, '0);
        rd_chk("vector off", `DVIC_A_VEC, 32'h7fff80);
        // back-to-back set, cross-clear and read
        acc(1'b1, NEN, 32'h400);
        acc(1'b1, FEN, 32'h400);
        acc(1'b0, NEN, '0);
        idle();
        chk_word("normal enable", 32'h3a1, reg_rdata);
        rd_chk("fast enable", FEN, 32'h400);
        rd_chk("unmapped", 32'hffff0018, '0);
        // mid-run reset, then enables, status, base, vector, write-only ports and prio C read back zero
        n_lvl <= '0;
        resetn <= 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        foreach (rst_addrs[i]) begin
            rd_chk("reset value", rst_addrs[i], '0);
        end
        finish_test();
    end
endmodule // dvic_tb_top

bind dvic_top dvic_props #(.NUM_SRC(NUM_SRC)) dvic_props_i (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .norm_src_in(norm_src_in), .fast_src_in(fast_src_in), .norm_exc(norm_exc), .fast_exc(fast_exc));
